/* File: design/csw_pkg.sv */
// constants, types and decode helpers for the chip select and wait controller
package csw_pkg;
  localparam int unsigned NUM_SPACES = 4;
  localparam int unsigned NUM_PINS   = 3;
  localparam int unsigned AXI_AW     = 12;

  // register indices; the byte address on the bus is four times the index
  localparam logic [3:0][9:0] IDX_CTL   = {10'h0c3, 10'h0c2, 10'h0c1, 10'h0c0};
  localparam logic [3:0][9:0] IDX_START = {10'h0ce, 10'h0cc, 10'h0ca, 10'h0c8};
  localparam logic [3:0][9:0] IDX_MASK  = {10'h0cf, 10'h0cd, 10'h0cb, 10'h0c9};
  localparam logic [9:0]      IDX_DEFAULT = 10'h0c7;
  localparam logic [9:0]      IDX_STATUS  = 10'h0d0;
  localparam logic [9:0]      IDX_P4DIR   = 10'h0d1;
  localparam logic [9:0]      IDX_P4FN    = 10'h0d2;

  // control register fields
  localparam int unsigned CTL_EN       = 7;
  localparam int unsigned CTL_AREA     = 6;
  localparam int unsigned CTL_BUS      = 3;
  localparam int unsigned CTL_WAIT_LSB = 0;
  localparam logic [7:0]  CTL_WMASK    = 8'hbf;
  localparam logic [7:0]  CTL2_WMASK   = 8'hff;
  localparam logic [7:0]  DEF_WMASK    = 8'h0f;

  // status register fields
  localparam int unsigned STAT_HIT_LSB  = 0;
  localparam int unsigned STAT_WAIT_LSB = 8;
  localparam int unsigned STAT_BUS      = 12;

  // reset values
  localparam logic [7:0] START_RST = 8'hff;
  localparam logic [7:0] MASK_RST  = 8'hff;
  localparam logic [7:0] CTL_RST   = 8'h00;
  localparam logic [7:0] CTL2_RST  = 8'h80;
  localparam logic [7:0] DEF_RST   = 8'h00;
  localparam logic [7:0] P4_RST    = 8'h00;

  // external range that space 2 covers in whole-memory mode
  localparam logic [23:0] WHOLE_LO = 24'h003800;
  localparam logic [23:0] WHOLE_HI = 24'hfe7fff;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic       width8;
    logic [3:0] waits;
  } cycle_cfg_t;

  typedef enum logic [1:0] {
    T_IDLE  = 2'b01,
    T_COUNT = 2'b10
  } timer_state_t;

  typedef struct packed {
    timer_state_t st;
    logic [3:0]   cnt;
  } timer_q_t;

  typedef struct packed {
    logic [3:0][7:0] ctl;
    logic [7:0]      dflt;
    logic [3:0][7:0] start;
    logic [3:0][7:0] mask;
    logic [7:0]      p4dir;
    logic [7:0]      p4fn;
    logic            aw_v;
    logic [9:0]      aw_idx;
    logic            w_v;
    logic [7:0]      w_d;
    logic            w_s;
    logic            b_v;
    logic [1:0]      b_r;
    logic            r_v;
    logic [31:0]     r_d;
    logic [1:0]      r_r;
    logic            cyc_prev;
    logic [4:0]      last_hit;
    cycle_cfg_t      last_cfg;
  } ctl_state_t;

  // address bits left out of the compare; bits 7:0 never take part
  function automatic logic [23:0] ignore_bits(input logic [1:0] kind,
                                              input logic [7:0] m);
    logic [23:0] ig;
    ig = 24'h0000ff;
    case (kind)
      2'd0: begin
        ig[20:15] = m[7:2];
        ig[14:9]  = {6{m[1]}};
        ig[8]     = m[0];
      end
      2'd1: begin
        ig[21:16] = m[7:2];
        ig[15:9]  = {7{m[1]}};
        ig[8]     = m[0];
      end
      default: begin
        ig[22:15] = m;
        ig[14:8]  = 7'h7f;
      end
    endcase
    return ig;
  endfunction

  function automatic logic [3:0] wait_count(input logic [2:0] code);
    logic [3:0] w;
    case (code)
      3'b000:  w = 4'h2;
      3'b001:  w = 4'h1;
      3'b010:  w = 4'h1;
      3'b011:  w = 4'h0;
      3'b101:  w = 4'h3;
      3'b110:  w = 4'h4;
      3'b111:  w = 4'h8;
      default: w = 4'h2;                     // reserved code runs as reset value
    endcase
    return w;
  endfunction

  function automatic logic reg_mapped(input logic [9:0] idx);
    logic ok;
    ok = (idx == IDX_DEFAULT) || (idx == IDX_STATUS) ||
         (idx == IDX_P4DIR) || (idx == IDX_P4FN);
    for (int i = 0; i < NUM_SPACES; i++) begin
      ok = ok || (idx == IDX_CTL[i]) || (idx == IDX_START[i]) ||
           (idx == IDX_MASK[i]);
    end
    return ok;
  endfunction
endpackage

/* File: design/space_match.sv */
// address compare for one programmable space
`timescale 1ns/10ps
`default_nettype none
module space_match
  import csw_pkg::*;
#(
  parameter logic [1:0] KIND = 2'd0
) (
  input  wire logic [23:0] addr,        // current bus address
  input  wire logic        enable,      // master enable of the space
  input  wire logic        whole_mode,  // cover the whole external range
  input  wire logic [7:0]  start,       // upper base bits
  input  wire logic [7:0]  mask,        // size mask register
  output logic             hit          // address falls in the space
);
  logic [23:0] base;
  logic [23:0] ign;
  logic        in_area;
  logic        in_whole;

  assign base     = {start, 16'h0000};
  assign ign      = ignore_bits(KIND, mask);
  assign in_area  = ((addr ^ base) & ~ign) == 24'h000000;
  assign in_whole = (addr >= WHOLE_LO) && (addr <= WHOLE_HI);
  assign hit      = enable && (whole_mode ? in_whole : in_area);
endmodule
`default_nettype wire

/* File: design/wait_timer.sv */
// wait state sequencer that ends each external bus cycle
`timescale 1ns/10ps
`default_nettype none
module wait_timer
  import csw_pkg::*;
(
  input  wire logic       aclk,     // system clock
  input  wire logic       aresetn,  // synchronous reset, active low
  input  wire logic       start,    // first cycle of a bus cycle
  input  wire logic [3:0] waits,    // wait states for this cycle
  output logic            ready,    // bus cycle may end now
  output logic            busy      // a cycle is being timed
);
  localparam timer_q_t T_RST = '{st: T_IDLE, cnt: 4'h0};

  timer_q_t q;
  timer_q_t d;

  always_comb begin
    d     = q;
    ready = 1'b0;
    unique case (q.st)
      T_IDLE: begin
        if (start) begin
          d.st  = T_COUNT;
          d.cnt = waits;
        end
      end
      T_COUNT: begin
        if (q.cnt == 4'h0) begin
          ready = 1'b1;
          d.st  = T_IDLE;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      default: d = T_RST;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= T_RST;
    end else begin
      q <= d;
    end
  end

  assign busy = (q.st == T_COUNT);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_zero_wait;
    (start && !busy && waits == 4'h0) |=> ready;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("zero wait cycle did not end at once");

  property p_eight_wait;
    (start && !busy && waits == 4'h8) |=> !ready [*8] ##1 ready;
  endproperty
  a_eight_wait: assert property (p_eight_wait)
    else $error("eight wait cycle ended at the wrong edge");
endmodule
`default_nettype wire

/* File: design/chip_select_wait_controller.sv */
// chip select and wait controller with its register file on AXI4-Lite
//
// Contract
// - four spaces plus default, each own width/waits
// - match in space 0-2 drives its select low
// - select reaches pin only when port enabled
// - space 3 has settings but no select pin
// - every bus cycle compares address, uses match
// - start register gives address bits 23:16
// - only unmasked address bits are compared
// - space 0 mask covers bits 20:8
// - space 1 mask covers bits 21:8
// - spaces 2 and 3 mask bits 22:15
// - reset sets start and mask to ones
// - reset disables spaces 0, 1 and 3
// - reset enables space 2 in whole mode
// - unmatched access uses default region settings
// - lowest numbered matching space wins
// - enable bit 7 gates space matching
// - bit 3 one means 8-bit bus
// - wait field decodes to fixed wait counts
// - code 010 gives one fixed wait
// - area select zero puts space 2 in whole-memory mode
`timescale 1ns/10ps
`default_nettype none
module chip_select_wait_controller
  import csw_pkg::*;
(
  input  wire logic              aclk,            // system clock
  input  wire logic              aresetn,         // sync reset, active low
  input  wire logic [AXI_AW-1:0] awaddr,          // write address
  input  wire logic              awvalid,         // write address valid
  output logic                   awready,         // write address ready
  input  wire logic [31:0]       wdata,           // write data
  input  wire logic [3:0]        wstrb,           // write byte strobes
  input  wire logic              wvalid,          // write data valid
  output logic                   wready,          // write data ready
  output logic [1:0]             bresp,           // write response
  output logic                   bvalid,          // write response valid
  input  wire logic              bready,          // write response ready
  input  wire logic [AXI_AW-1:0] araddr,          // read address
  input  wire logic              arvalid,         // read address valid
  output logic                   arready,         // read address ready
  output logic [31:0]            rdata,           // read data
  output logic [1:0]             rresp,           // read response
  output logic                   rvalid,          // read data valid
  input  wire logic              rready,          // read data ready
  input  wire logic [23:0]       bus_addr,        // cpu address of the cycle
  input  wire logic              bus_cycle,       // external bus cycle active
  input  wire logic              internal_area,   // address is on-chip
  output logic                   space0_select_n, // space 0 select, low
  output logic                   space1_select_n, // space 1 select, low
  output logic                   space2_select_n, // space 2 select, low
  output var cycle_cfg_t         cycle_cfg,       // width and waits in use
  output logic                   cycle_ready      // bus cycle may end
);
  localparam ctl_state_t RST = '{
    ctl:   {CTL_RST, CTL2_RST, CTL_RST, CTL_RST},
    dflt:  DEF_RST,
    start: {4{START_RST}},
    mask:  {4{MASK_RST}},
    p4dir: P4_RST,
    p4fn:  P4_RST,
    default: '0
  };

  ctl_state_t q;
  ctl_state_t d;

  logic [NUM_SPACES-1:0] hit;
  logic [2:0]            win;
  logic [4:0]            win_oh;
  logic [7:0]            cfg_reg;
  logic [NUM_PINS-1:0]   sel_n;
  logic                  cyc_start;
  logic [9:0]            ridx;
  logic [31:0]           rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  genvar g;
  generate
    for (g = 0; g < NUM_SPACES; g++) begin : gen_space
      localparam logic [1:0] KIND = (g < 2) ? 2'(g) : 2'd2;
      space_match #(.KIND(KIND)) u_match (
        .addr       (bus_addr),
        .enable     (q.ctl[g][CTL_EN]),
        .whole_mode ((g == 2) && !q.ctl[g][CTL_AREA]),
        .start      (q.start[g]),
        .mask       (q.mask[g]),
        .hit        (hit[g])
      );
    end
  endgenerate

  // lowest numbered space wins; 4 means the default region
  always_comb begin
    win    = 3'd4;
    win_oh = 5'h00;
    for (int i = NUM_SPACES - 1; i >= 0; i--) begin
      if (hit[i]) begin
        win = 3'(i);
      end
    end
    win_oh[win] = 1'b1;
  end

  // the default region only applies when nothing matched
  assign cfg_reg = (win == 3'd4) ? q.dflt : q.ctl[win[1:0]];
  assign cycle_cfg.width8 = cfg_reg[CTL_BUS];
  assign cycle_cfg.waits  = wait_count(cfg_reg[CTL_WAIT_LSB +: 3]);

  // space 3 has no pin; external decoding must select its parts
  generate
    for (g = 0; g < NUM_PINS; g++) begin : gen_pin
      assign sel_n[g] = !(bus_cycle && !internal_area &&
                          (win == 3'(g)) &&
                          q.p4dir[g] && q.p4fn[g]);
    end
  endgenerate

  assign space0_select_n = sel_n[0];
  assign space1_select_n = sel_n[1];
  assign space2_select_n = sel_n[2];

  assign cyc_start = bus_cycle && !q.cyc_prev;

  wait_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (cyc_start),
    .waits   (cycle_cfg.waits),
    .ready   (cycle_ready),
    .busy    ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // register read mux; control registers are write only and read as zero

  assign ridx = araddr[AXI_AW-1:2];

  always_comb begin
    rd_word = 32'h00000000;
    for (int i = 0; i < NUM_SPACES; i++) begin
      if (ridx == IDX_START[i]) begin
        rd_word[7:0] = q.start[i];
      end
      if (ridx == IDX_MASK[i]) begin
        rd_word[7:0] = q.mask[i];
      end
    end
    if (ridx == IDX_P4DIR) begin
      rd_word[7:0] = q.p4dir;
    end
    if (ridx == IDX_P4FN) begin
      rd_word[7:0] = q.p4fn;
    end
    if (ridx == IDX_STATUS) begin
      rd_word[STAT_HIT_LSB +: 5]  = q.last_hit;
      rd_word[STAT_WAIT_LSB +: 4] = q.last_cfg.waits;
      rd_word[STAT_BUS]           = q.last_cfg.width8;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    if (awvalid && !q.aw_v) begin
      d.aw_v   = 1'b1;
      d.aw_idx = awaddr[AXI_AW-1:2];
    end
    if (wvalid && !q.w_v) begin
      d.w_v = 1'b1;
      d.w_d = wdata[7:0];
      d.w_s = wstrb[0];
    end
    if (q.b_v && bready) begin
      d.b_v = 1'b0;
    end
    // write commits once both halves are held and the response is free
    if (q.aw_v && q.w_v && !q.b_v) begin
      d.aw_v = 1'b0;
      d.w_v  = 1'b0;
      d.b_v  = 1'b1;
      d.b_r  = reg_mapped(q.aw_idx) ? RESP_OKAY : RESP_DECERR;
      if (q.w_s) begin
        for (int i = 0; i < NUM_SPACES; i++) begin
          if (q.aw_idx == IDX_CTL[i]) begin
            d.ctl[i] = q.w_d & ((i == 2) ? CTL2_WMASK : CTL_WMASK);
          end
          if (q.aw_idx == IDX_START[i]) begin
            d.start[i] = q.w_d;
          end
          if (q.aw_idx == IDX_MASK[i]) begin
            d.mask[i] = q.w_d;
          end
        end
        if (q.aw_idx == IDX_DEFAULT) begin
          d.dflt = q.w_d & DEF_WMASK;
        end
        if (q.aw_idx == IDX_P4DIR) begin
          d.p4dir = q.w_d;
        end
        if (q.aw_idx == IDX_P4FN) begin
          d.p4fn = q.w_d;
        end
      end
    end
    if (q.r_v && rready) begin
      d.r_v = 1'b0;
    end
    if (arvalid && !q.r_v) begin
      d.r_v = 1'b1;
      d.r_d = rd_word;
      d.r_r = reg_mapped(ridx) ? RESP_OKAY : RESP_DECERR;
    end
    // status keeps the decision taken at the start of the last cycle
    d.cyc_prev = bus_cycle;
    if (cyc_start) begin
      d.last_hit = win_oh;
      d.last_cfg = cycle_cfg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign awready = !q.aw_v;
  assign wready  = !q.w_v;
  assign bvalid  = q.b_v;
  assign bresp   = q.b_r;
  assign arready = !q.r_v;
  assign rvalid  = q.r_v;
  assign rdata   = q.r_d;
  assign rresp   = q.r_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_reset_values;
    $rose(aresetn) |-> q.start == {4{START_RST}} &&
      q.mask == {4{MASK_RST}} && !q.ctl[0][CTL_EN] && !q.ctl[1][CTL_EN] &&
      !q.ctl[3][CTL_EN] && q.ctl[2][CTL_EN] && !q.ctl[2][CTL_AREA];
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("space registers wrong after reset");

  property p_priority;
    (hit[0] && hit[2]) |->
      cycle_cfg.width8 == q.ctl[0][CTL_BUS] && win == 3'd0;
  endproperty
  a_priority: assert property (p_priority)
    else $error("overlap not resolved to lowest space");

  property p_default;
    (hit == 4'h0) |-> cycle_cfg.width8 == q.dflt[CTL_BUS] &&
      cycle_cfg.waits == wait_count(q.dflt[2:0]);
  endproperty
  a_default: assert property (p_default)
    else $error("unmatched access not using default settings");

  property p_space3;
    (bus_cycle && win == 3'd3) |-> (&sel_n) &&
      cycle_cfg.width8 == q.ctl[3][CTL_BUS];
  endproperty
  a_space3: assert property (p_space3)
    else $error("space 3 match drove a select or lost its width");

  property p_pin_gate;
    !(q.p4dir[0] && q.p4fn[0]) |-> space0_select_n;
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("select driven while port is not configured");

  property p_select;
    (bus_cycle && !internal_area && hit[1] && !hit[0] &&
     q.p4dir[1] && q.p4fn[1]) |-> !space1_select_n && space0_select_n;
  endproperty
  a_select: assert property (p_select)
    else $error("space 1 select missing on match");

  property p_whole;
    (q.ctl[2][CTL_EN] && !q.ctl[2][CTL_AREA] &&
     bus_addr >= WHOLE_LO && bus_addr <= WHOLE_HI) |-> hit[2];
  endproperty
  a_whole: assert property (p_whole)
    else $error("whole-memory space 2 missed an address");

  property p_disabled;
    !q.ctl[0][CTL_EN] |-> !hit[0] && win != 3'd0;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled space 0 matched");

  property p_fixed_wait;
    (cfg_reg[CTL_WAIT_LSB +: 3] == 3'b010) |-> cycle_cfg.waits == 4'h1;
  endproperty
  a_fixed_wait: assert property (p_fixed_wait)
    else $error("code 010 did not give one wait");

  property p_status;
    cyc_start |=> q.last_hit == $past(win_oh) &&
      q.last_cfg == $past(cycle_cfg);
  endproperty
  a_status: assert property (p_status)
    else $error("status did not capture the cycle decision");

  property p_idle_select;
    !bus_cycle |-> (&sel_n);
  endproperty
  a_idle_select: assert property (p_idle_select)
    else $error("select driven outside a bus cycle");

  property p_internal;
    internal_area |-> (&sel_n);
  endproperty
  a_internal: assert property (p_internal)
    else $error("select driven for an on-chip address");

  property p_base_match;
    (q.ctl[1][CTL_EN] && q.mask[1] == 8'h00 &&
     bus_addr[23:8] == {q.start[1], 8'h00}) |-> hit[1];
  endproperty
  a_base_match: assert property (p_base_match)
    else $error("space 1 missed an address at its base");

  property p_space3_waits;
    (win == 3'd3) |-> cycle_cfg.waits == wait_count(q.ctl[3][2:0]);
  endproperty
  a_space3_waits: assert property (p_space3_waits)
    else $error("space 3 match lost its wait count");
endmodule
`default_nettype wire

/* File: verification/ext_mem_model.sv */
// external memory devices that watch the three chip selects
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
  input  wire logic       aclk,      // system clock
  input  wire logic       aresetn,   // sync reset, active low
  input  wire logic       bus_cycle, // external bus cycle active
  input  wire logic [2:0] sel_n,     // selects of spaces 2..0, low
  input  wire logic       ready,     // bus cycle ends now
  output logic      [2:0] seen_n     // selects held low all last cycle
);
  logic [2:0] acc_q;
  logic       prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // a select that rises in mid-cycle cuts a slow part off early, so a
  // device only counts as selected if its select stayed low throughout
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q  <= 3'h0;
      prev_q <= 1'b0;
      seen_n <= 3'h7;
    end else begin
      prev_q <= bus_cycle;
      acc_q  <= (bus_cycle && !prev_q) ? sel_n : (acc_q | sel_n);
      if (ready) begin
        seen_n <= acc_q | sel_n;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/chip_select_wait_controller_test.sv */
// self-checking bench for the chip select and wait controller
`timescale 1ns/10ps
`default_nettype none
module chip_select_wait_controller_test
  import csw_pkg::*;
;
  localparam logic [3:0]  WAITS [8] = '{4'h2, 4'h1, 4'h1, 4'h0,
                                        4'h2, 4'h3, 4'h4, 4'h8};
  localparam logic [23:0] EDGE_A [4] = '{24'h0037ff, 24'h003800,
                                         24'hfe7fff, 24'hfe8000};
  logic              aclk, aresetn, awvalid, wvalid, bready;
  logic              arvalid, rready, bus_cycle, internal_area;
  logic              awready, wready, bvalid, arready, rvalid, cycle_ready;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [23:0]       bus_addr;
  logic [2:0]        sel_n, seen_n;
  cycle_cfg_t        cfg;
  int                failures, checks, cyc_count;

  chip_select_wait_controller chip_select_wait_controller_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .bus_addr(bus_addr), .bus_cycle(bus_cycle),
    .internal_area(internal_area), .space0_select_n(sel_n[0]),
    .space1_select_n(sel_n[1]), .space2_select_n(sel_n[2]),
    .cycle_cfg(cfg), .cycle_ready(cycle_ready)
  );

  ext_mem_model ext_mem_model_i (
    .aclk(aclk), .aresetn(aresetn), .bus_cycle(bus_cycle),
    .sel_n(sel_n), .ready(cycle_ready), .seen_n(seen_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask

  // handshake is judged at the negedge; ready is a flop, so that value
  // is the one sampled at the following rising edge
  task automatic wr(input logic [9:0] i, input logic [7:0] d,
                    input logic s, input logic [1:0] er = RESP_OKAY);
    logic a, w, ta, tw;
    a = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr  <= {i, 2'b00};
    wdata   <= {24'h0, d};
    wstrb   <= {3'h0, s};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(a && w)) begin
      @(negedge aclk);
      ta = !a && awready;
      tw = !w && wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      a = a || ta;
      w = w || tw;
    end
    do @(negedge aclk); while (!bvalid);
    chk(bresp, er, "write resp");
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rchk(input logic [9:0] i, input logic [31:0] e,
                      input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    araddr  <= {i, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    chk(rdata, e, "read data");
    chk(rresp, er, "read resp");
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // selects and config are judged in the first cycle of the bus cycle
  task automatic cyc(input logic [23:0] a, input logic in,
                     input logic [2:0] es, input logic [4:0] ec);
    int n;
    @(posedge aclk);
    bus_addr      <= a;
    internal_area <= in;
    bus_cycle     <= 1'b1;
    @(negedge aclk);
    chk(sel_n, es, "select");
    chk(cfg, ec, "cycle config");
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!cycle_ready && n < 20);
    chk(n, ec[3:0] + 1, "cycle length");
    @(posedge aclk);
    bus_cycle <= 1'b0;
    @(negedge aclk);
    chk(seen_n, es, "held select");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      rchk(IDX_START[i], 32'hff);
      rchk(IDX_MASK[i], 32'hff);
    end
    rchk(IDX_CTL[0], 32'h0);
    rchk(10'h3ff, 32'h0, RESP_DECERR);
    wr(10'h3fe, 8'h5a, 1'b1, RESP_DECERR);
    for (int i = 0; i < 4; i++) begin
      cyc(EDGE_A[i], 1'b0, 3'h7, 5'h02);
      rchk(IDX_STATUS, (i[0] ^ i[1]) ? 32'h204 : 32'h210);
    end
  endtask

  task automatic t_port();
    wr(IDX_P4DIR, 8'h07, 1'b1);
    cyc(24'h100000, 1'b0, 3'h7, 5'h02);
    wr(IDX_P4FN, 8'h07, 1'b1);
    cyc(24'h100000, 1'b0, 3'h3, 5'h02);
    cyc(24'h100000, 1'b1, 3'h7, 5'h02);
  endtask

  task automatic t_space0();
    wr(IDX_START[0], 8'h01, 1'b1);
    wr(IDX_MASK[0], 8'h07, 1'b1);
    wr(IDX_CTL[0], 8'h83, 1'b1);
    cyc(24'h010000, 1'b0, 3'h6, 5'h00);
    cyc(24'h01ffff, 1'b0, 3'h6, 5'h00);
    cyc(24'h020000, 1'b0, 3'h3, 5'h02);
    wr(IDX_MASK[0], 8'h05, 1'b1);
    cyc(24'h0181ff, 1'b0, 3'h6, 5'h00);
    cyc(24'h010200, 1'b0, 3'h3, 5'h02);
  endtask

  task automatic t_waits();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(IDX_CTL[0], {4'h8, c[0], c}, 1'b1);
      cyc(24'h010000, 1'b0, 3'h6, {c[0], WAITS[i]});
    end
  endtask

  task automatic t_space23();
    wr(IDX_DEFAULT, 8'h0b, 1'b1);
    cyc(24'h100000, 1'b0, 3'h3, 5'h02);
    wr(IDX_START[2], 8'hff, 1'b1);
    wr(IDX_MASK[2], 8'h00, 1'b1);
    wr(IDX_CTL[2], 8'hc5, 1'b1);
    cyc(24'h100000, 1'b0, 3'h7, 5'h10);
    cyc(24'hff7fff, 1'b0, 3'h3, 5'h03);
    cyc(24'hff8000, 1'b0, 3'h7, 5'h10);
    wr(IDX_START[3], 8'h40, 1'b1);
    wr(IDX_MASK[3], 8'h00, 1'b1);
    cyc(24'h400000, 1'b0, 3'h7, 5'h10);
    wr(IDX_CTL[3], 8'h8e, 1'b1);
    cyc(24'h400000, 1'b0, 3'h7, 5'h14);
    cyc(24'h408000, 1'b0, 3'h7, 5'h10);
  endtask

  task automatic t_enable();
    wr(IDX_START[1], 8'h50, 1'b1);
    wr(IDX_MASK[1], 8'h00, 1'b1);
    cyc(24'h500000, 1'b0, 3'h7, 5'h10);
    wr(IDX_CTL[1], 8'h81, 1'b1);
    cyc(24'h500000, 1'b0, 3'h5, 5'h01);
    cyc(24'h5000ff, 1'b1, 3'h7, 5'h01);
    cyc(24'h500100, 1'b0, 3'h7, 5'h10);
    wr(IDX_START[1], 8'h99, 1'b0);
    rchk(IDX_START[1], 32'h50);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // generous ceiling: the whole sequence needs well under 3000 cycles
  always @(posedge aclk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 20000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    failures = 0;
    checks = 0;
    cyc_count = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {bus_cycle, internal_area} = 2'h0;
    awaddr = '0;
    araddr = '0;
    wdata = 32'h0;
    wstrb = 4'h0;
    bus_addr = 24'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_port();
    t_space0();
    t_waits();
    t_space23();
    t_enable();
    print_verdict();
  end
endmodule
`default_nettype wire
